/* File: inc/filter_setup_pkg.sv */
// Constants for the filter setup register bank
package filter_setup_pkg;
   // Register map: printed offsets are register indices, byte address = 4 * index
   localparam int          NUM_SETUPS     = 8;
   localparam logic [7:0]  FILT_IDX_FIRST = 8'h28;
   localparam logic [7:0]  FILT_IDX_LAST  = 8'h2F;
   localparam logic [15:0] FILT_RESET     = 16'h0500;
   // Field positions and masks
   localparam int          DIRECT_BIT     = 15;
   localparam int          POSTEN_BIT     = 11;
   localparam int          POSTSEL_LSB    = 8;
   localparam int          ORDER_LSB      = 5;
   localparam int          RATE_LSB       = 0;
   localparam logic [15:0] WRITE_MASK     = 16'h8F7F;
   localparam logic [15:0] DIRECT_MASK    = 16'h7FFF;
   // Filter order codes
   localparam logic [1:0]  ORDER_SINC5    = 2'h0;
   localparam logic [1:0]  ORDER_SINC3    = 2'h3;
   // Post filter codes
   localparam logic [2:0]  POST_27        = 3'h2;
   localparam logic [2:0]  POST_25        = 3'h3;
   localparam logic [2:0]  POST_20        = 3'h5;
   localparam logic [2:0]  POST_16        = 3'h6;
   // Direct decimation factor multiplier
   localparam logic [5:0]  DIRECT_MULT    = 6'h20;
   // Highest defined output rate code
   localparam logic [4:0]  RATE_MAX       = 5'h16;
   // Filter kinds presented to the datapath
   typedef enum logic [1:0] {KIND_SINC5, KIND_SINC3, KIND_DIRECT} filt_kind_t;
endpackage

/* File: core/filter_decode.sv */
// Decode of one filter setup word into the settings the filter datapath uses
`timescale 1ns/10ps
module filter_decode
   import filter_setup_pkg::*;
(
   // Setup word
   input  wire logic [15:0]          setupWord,
   // Decoded settings
   output filter_setup_pkg::filt_kind_t filtKind,
   output logic      [20:0]          directDecim,
   output logic                      postActive,
   output logic      [2:0]           postSelect,
   output logic      [4:0]           rateCode,
   output logic                      codeReserved
);
   // Direct mode overrides every other field except postSelect, which still passes bits 10:8; post filter needs sinc5+sinc1
   always_comb begin
      filtKind     = KIND_SINC5;
      directDecim  = 21'h000000;
      postActive   = 1'b0;
      postSelect   = setupWord[POSTSEL_LSB +: 3];
      rateCode     = setupWord[RATE_LSB +: 5];
      codeReserved = 1'b0;
      if (setupWord[DIRECT_BIT]) begin
         filtKind    = KIND_DIRECT;
         directDecim = 21'(setupWord[14:0]) * 21'(DIRECT_MULT);
         rateCode    = 5'h00;
      end else begin
         case (setupWord[ORDER_LSB +: 2])
            ORDER_SINC5: filtKind = KIND_SINC5;
            ORDER_SINC3: filtKind = KIND_SINC3;
            default: begin
               filtKind     = KIND_SINC5;
               codeReserved = 1'b1;
            end
         endcase
         // Post filter only counts with the sinc5+sinc1 order
         postActive = setupWord[POSTEN_BIT] &&
                      (setupWord[ORDER_LSB +: 2] == ORDER_SINC5);
         if (postActive && !(postSelect == POST_27 || postSelect == POST_25 ||
                             postSelect == POST_20 || postSelect == POST_16))
            codeReserved = 1'b1;
         if (rateCode > RATE_MAX)
            codeReserved = 1'b1;
      end
   end
endmodule

/* File: core/adc_filter_setup_config.sv */
// APB register bank of eight filter setup words with conversion restart
`timescale 1ns/10ps
module adc_filter_setup_config
   import filter_setup_pkg::*;
(
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [9:0]              paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic                         pready,
   output logic      [31:0]             prdata,
   output logic                         pslverr,
   // Converter side
   input  wire logic [2:0]              activeSetup,
   output logic                         convRestart,
   output filter_setup_pkg::filt_kind_t filtKind,
   output logic      [20:0]             directDecim,
   output logic                         postActive,
   output logic      [2:0]              postSelect,
   output logic      [4:0]              rateCode,
   output logic                         codeReserved
);
   import filter_setup_pkg::*;

   logic [15:0] setupBank_r [NUM_SETUPS];
   logic [15:0] setupWord;
   logic [7:0]  regIndex;
   logic [2:0]  slot;
   logic        hit;
   logic        accessDone;
   logic        restart_r;
   filt_kind_t  kindNxt;
   logic [20:0] decimNxt;
   logic        postNxt;
   logic [2:0]  selNxt;
   logic [4:0]  rateNxt;
   logic        resvNxt;

   // Byte address to register index; low two bits ignored
   function automatic logic [7:0] wordIndex(input logic [9:0] addr);
      return addr[9:2];
   endfunction

   // Access phase decode; every transfer completes with no wait state
   assign regIndex   = wordIndex(paddr);
   assign hit        = (regIndex >= FILT_IDX_FIRST) && (regIndex <= FILT_IDX_LAST);
   assign slot       = regIndex[2:0];
   assign accessDone = psel && penable;
   assign pready     = 1'b1;
   assign pslverr    = accessDone && !hit;

   // Register writes; byte strobes honoured, reserved bits stay zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_SETUPS; i++) begin
            setupBank_r[i] <= FILT_RESET;
         end
      end else if (accessDone && pwrite && hit) begin
         if (pstrb[0]) begin
            setupBank_r[slot][7:0] <= pwdata[7:0] & WRITE_MASK[7:0];
         end
         if (pstrb[1]) begin
            setupBank_r[slot][15:8] <= pwdata[15:8] & WRITE_MASK[15:8];
         end
      end
   end

   // Restart pulse one cycle after any accepted write to the bank
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         restart_r <= 1'b0;
      end else begin
         restart_r <= accessDone && pwrite && hit;
      end
   end
   assign convRestart = restart_r;

   // Read data registered on the setup phase so it is stable during access
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (hit) begin
            prdata <= {16'h0000, setupBank_r[slot]};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // Settings of the setup assigned to the converting channel
   assign setupWord = setupBank_r[activeSetup];

   filter_decode u_decode (
      .setupWord    (setupWord),
      .filtKind     (kindNxt),
      .directDecim  (decimNxt),
      .postActive   (postNxt),
      .postSelect   (selNxt),
      .rateCode     (rateNxt),
      .codeReserved (resvNxt)
   );

   // Decoded settings registered so datapath inputs come from flip-flops
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         filtKind     <= KIND_SINC5;
         directDecim  <= 21'h000000;
         postActive   <= 1'b0;
         postSelect   <= POST_20;
         rateCode     <= 5'h00;
         codeReserved <= 1'b0;
      end else begin
         filtKind     <= kindNxt;
         directDecim  <= decimNxt;
         postActive   <= postNxt;
         postSelect   <= selNxt;
         rateCode     <= rateNxt;
         codeReserved <= resvNxt;
      end
   end
endmodule

/* File: tb/adc_filter_setup_props.sv */
// Concurrent checks on the filter setup register bank ports
`timescale 1ns/10ps
module adc_filter_setup_props
   import filter_setup_pkg::*;
(
   // Clock, reset and bus
   input wire logic                        sys_clk,
   input wire logic                        rst,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [9:0]                  paddr,
   input wire logic [31:0]                 prdata,
   input wire logic                        pslverr,
   // Converter side
   input wire logic                        convRestart,
   input wire filter_setup_pkg::filt_kind_t filtKind,
   input wire logic [20:0]                 directDecim,
   input wire logic                        postActive,
   input wire logic [4:0]                  rateCode
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Address decode kept apart so each check reads plainly
   logic mapped;
   assign mapped = (paddr[9:2] >= FILT_IDX_FIRST) && (paddr[9:2] <= FILT_IDX_LAST);
   sequence s_access; psel && penable; endsequence
   sequence s_write; psel && penable && pwrite && mapped; endsequence
   a_restart_after_write: assert property (s_write |=> convRestart)
      else $error("no restart after setup write");
   a_restart_has_cause: assert property (
      convRestart |-> $past(psel && penable && pwrite && mapped))
      else $error("restart without a setup write");
   a_restart_pulse: assert property (convRestart |=> !convRestart)
      else $error("restart longer than one cycle");
   a_unmapped_error: assert property (s_access |-> pslverr == !mapped)
      else $error("error response does not match address");
   a_reserved_read_zero: assert property (
      s_access ##0 !pwrite |-> (prdata & 32'hFFFF7080) == 32'h0)
      else $error("reserved read bits not zero");
   a_unmapped_read_zero: assert property (
      s_access ##0 !pwrite && !mapped |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_direct_fields: assert property (
      filtKind == KIND_DIRECT |-> rateCode == 5'h00 && !postActive)
      else $error("direct mode left other options live");
   a_decim_direct_only: assert property (filtKind != KIND_DIRECT |-> directDecim == 21'h0)
      else $error("decimation value outside direct mode");
   a_post_order_only: assert property (postActive |-> filtKind == KIND_SINC5)
      else $error("post filter active with wrong order");
endmodule
bind adc_filter_setup_config adc_filter_setup_props i_props (.sys_clk, .rst, .psel, .penable,
   .pwrite, .paddr, .prdata, .pslverr, .convRestart, .filtKind, .directDecim, .postActive, .rateCode);

/* File: tb/adc_filter_setup_config_tb_top.sv */
// Self-checking bench for the filter setup register bank
`timescale 1ns/10ps
module adc_filter_setup_config_tb_top;
   import filter_setup_pkg::*;
   logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic [2:0] activeSetup = 3'h0, postSelect;
   logic pready, pslverr, convRestart, postActive, codeReserved;
   filt_kind_t filtKind;
   logic [20:0] directDecim;
   logic [4:0] rateCode;
   // Decoded outputs packed as {kind, post, select, rate, reserved}
   logic [11:0] dec;
   assign dec = {filtKind, postActive, postSelect, rateCode, codeReserved};
   int errors = 0, cmp_count = 0;
   // Setup words and their decode {kind, post, select, rate, reserved}
   logic [15:0] w [7] = '{16'h8005, 16'h0B00, 16'h0B60, 16'h0A16, 16'h0017, 16'h0E03, 16'h0C00};
   logic [11:0] e [7] = '{12'h800, 12'h2C0, 12'h4C0, 12'h2AC, 12'h02F, 12'h386, 12'h301};
   always #2 sys_clk = ~sys_clk;
   adc_filter_setup_config i_adc_filter_setup_config (.sys_clk, .rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .activeSetup, .convRestart, .filtKind,
      .directDecim, .postActive, .postSelect, .rateCode, .codeReserved);
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; waits on pready since the slave sets the pace
   task apb(input logic wr, input logic [7:0] idx, input logic [15:0] d);
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, idx, 2'b00, 16'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task t_reset;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(FILT_IDX_FIRST + i), 16'h0);
         chk("reset word", rd, {16'h0, FILT_RESET});
      end
      apb(1'b0, 8'h27, 16'h0);
      chk("below map", {er, rd[30:0]}, 32'h80000000);
      apb(1'b1, 8'h30, 16'hFFFF);
      chk("above map", er, 32'h1);
   endtask
   task t_write;
      apb(1'b1, 8'h2B, 16'hFFFF);
      #1 chk("restart", convRestart, 32'h1);
      @(posedge sys_clk);
      #1 chk("restart end", convRestart, 32'h0);
      apb(1'b0, 8'h2B, 16'h0);
      chk("masked word", rd, 32'h8F7F);
      apb(1'b0, 8'h2A, 16'h0);
      chk("neighbour", rd, {16'h0, FILT_RESET});
      // Low byte lane only: upper byte keeps its reset value, bit 7 stays zero
      pstrb <= 4'h1;
      apb(1'b1, 8'h2A, 16'hFFFF);
      pstrb <= 4'hF;
      apb(1'b0, 8'h2A, 16'h0);
      chk("low lane", rd, {16'h0, FILT_RESET[15:8], 8'h7F});
   endtask
   // Outputs settle one edge after the write is taken; the check waits two
   task t_decode;
      activeSetup <= 3'h3;
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, 8'h2B, w[i]);
         repeat (2) @(posedge sys_clk);
         #1 chk("decode", dec, e[i]);
         chk("decim", directDecim, w[i][15] ? w[i][14:0] * 32 : 0);
      end
   endtask
   task t_setup;
      @(posedge sys_clk) activeSetup <= 3'h0;
      repeat (2) @(posedge sys_clk);
      #1 chk("setup 0", dec, 32'h140);
      @(posedge sys_clk) activeSetup <= 3'h3;
      repeat (2) @(posedge sys_clk);
      #1 chk("setup 3", dec, e[6]);
   endtask
   task end_sim;
      if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset;
      t_write;
      t_decode;
      t_setup;
      end_sim;
   end
   // Watchdog well beyond the hundred or so cycles the tests need
   initial begin
      repeat (3000) @(posedge sys_clk);
      errors++;
      end_sim;
   end
endmodule
